// ==== hw/tcc_defines.vh ====
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// Register offsets (printed offsets are not all multiples of four: index x4)
`define TCC_IDX_STATUS     8'h0c
`define TCC_IDX_CNT_HI     8'h0d
`define TCC_IDX_CNT_LO     8'h0e
`define TCC_IDX_MOD_HI     8'h0f
`define TCC_IDX_MOD_LO     8'h10
`define TCC_IDX_CH0_SC     8'h11
`define TCC_IDX_CH0_HI     8'h12
`define TCC_IDX_CH0_LO     8'h13
`define TCC_IDX_CH1_SC     8'h14
`define TCC_IDX_CH1_HI     8'h15
`define TCC_IDX_CH1_LO     8'h16

// Timer status and control fields
`define TCC_ST_OVF         7
`define TCC_ST_OVIE        6
`define TCC_ST_HALT        5
`define TCC_ST_CLR         4
`define TCC_ST_PS_HI       2
`define TCC_ST_RESET       8'h20

// Channel status and control fields
`define TCC_CH_FLAG        7
`define TCC_CH_IE          6
`define TCC_CH_LINK        5
`define TCC_CH_MODE        4
`define TCC_CH_ELS_HI      3
`define TCC_CH_ELS_LO      2
`define TCC_CH_TOV         1
`define TCC_CH_MAX         0

`define TCC_MOD_RESET      16'hffff
`define TCC_PS_EXT         3'h7

`endif

// ==== hw/tcc_timer.v ====
// Chosen here: the AXI4-Lite interface to the registers.
`include "tcc_defines.vh"

module tcc_timer #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 16
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              rstn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Pins
  input  wire              extTimerClockPin,
  input  wire              chan0PinIn,
  input  wire              chan1PinIn,
  output reg               chan0PinOut,
  output wire              chan0PinOe,
  output reg               chan1PinOut,
  output wire              chan1PinOe,
  // Interrupt requests
  output wire              overflowIrq,
  output wire              chan0Irq,
  output wire              chan1Irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0]       status;
  reg  [CNT_W-1:0] counter;
  reg  [CNT_W-1:0] modulo;
  reg  [7:0]       chanSc  [0:1];
  reg  [CNT_W-1:0] chanVal [0:1];
  // Arm bits remember a read of the set flag, which a clear must follow
  reg  [1:0]       chanArm;
  reg              ovfArm;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  reg  [ADDR_W-1:0] awAddr;
  reg               awHeld;
  reg  [31:0]       wData;
  reg  [3:0]        wStrb;
  reg               wHeld;
  // A write runs once both halves are held and the response slot is free
  wire              doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire              doRead  = s_axi_arvalid && !s_axi_rvalid;
  wire [ADDR_W-3:0] wIdx    = awAddr[ADDR_W-1:2];
  wire [ADDR_W-3:0] rIdx    = s_axi_araddr[ADDR_W-1:2];
  wire              wLane   = wStrb[0];
  wire [7:0]        wByte   = wData[7:0];

  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= {ADDR_W{1'b0}};
      wData  <= 32'h0;
      wStrb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Two flops before the edge detect; pinPrev only follows the second
  reg [2:0] pinMeta;
  reg [2:0] pinSync;
  reg [2:0] pinPrev;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
      pinPrev <= 3'h0;
    end else begin
      pinMeta <= {chan1PinIn, chan0PinIn, extTimerClockPin};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end
  // All reset low, the idle level, so no false edge follows reset
  wire [2:0] pinRise = pinSync & ~pinPrev;
  wire [2:0] pinFall = ~pinSync & pinPrev;

  // ****************************************************************
  // Prescaler and counter
  // ****************************************************************
  reg  [5:0] prescale;
  reg        tick;
  wire [6:0] tap;
  wire [2:0] psSel = status[`TCC_ST_PS_HI:0];
  genvar t;
  // Tap n pulses once every 2^n bus clocks, when the low n bits are all ones
  assign tap[0] = 1'b1;
  generate
    for (t = 1; t < 7; t = t + 1) begin : gTap
      assign tap[t] = &prescale[t-1:0];
    end
  endgenerate

  // Seven taps, external pin rising edges as the eighth source
  always @* begin
    case (psSel)
      `TCC_PS_EXT: tick = pinRise[0];
      default:     tick = tap[psSel];
    endcase
  end

  // ****************************************************************
  // Counter step
  // ****************************************************************
  wire             running = !status[`TCC_ST_HALT];
  wire             atTop   = (counter == modulo);
  wire             cntStep = running && tick;
  wire             wrap    = cntStep && atTop;
  // Compares look ahead, so the pin moves as the counter arrives at the
  // compare value and not one count later
  wire [CNT_W-1:0] nextCnt = atTop ? {CNT_W{1'b0}} : counter + {{(CNT_W-1){1'b0}}, 1'b1};

  // ****************************************************************
  // Channel logic
  // ****************************************************************
  wire       linked = chanSc[0][`TCC_CH_LINK];
  reg  [1:0] chanEvent;
  reg  [1:0] chanLevel;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gChan
      wire [7:0] sc      = chanSc[g];
      wire       els     = sc[`TCC_CH_ELS_HI] | sc[`TCC_CH_ELS_LO];
      wire       compare = sc[`TCC_CH_MODE] | (g == 0 && linked);
      wire       edgeHit = (sc[`TCC_CH_ELS_LO] & pinRise[g+1]) |
                           (sc[`TCC_CH_ELS_HI] & pinFall[g+1]);
      wire       match   = cntStep && (nextCnt == chanVal[g]);
      // Channel 1 stays silent while linked; its match drives channel 0's pin
      always @* begin
        chanEvent[g] = 1'b0;
        chanLevel[g] = 1'b0;
        if (!(g == 1 && linked) && els) begin
          chanEvent[g] = compare ? match : edgeHit;
          chanLevel[g] = compare && match;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Register updates
  // ****************************************************************
  integer i;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status   <= `TCC_ST_RESET;
      counter  <= {CNT_W{1'b0}};
      modulo   <= `TCC_MOD_RESET;
      prescale <= 6'h0;
      ovfArm   <= 1'b0;
      chanArm  <= 2'b00;
      chan0PinOut <= 1'b0;
      chan1PinOut <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        chanSc[i]  <= 8'h0;
        chanVal[i] <= {CNT_W{1'b0}};
      end
    end else begin
      prescale <= prescale + 6'h1;
      if (cntStep)
        counter <= nextCnt;

      // ****************************************************************
      // Capture on active edge
      // ****************************************************************
      for (i = 0; i < 2; i = i + 1) begin
        if (chanEvent[i] && !chanLevel[i])
          chanVal[i] <= counter;
      end

      // ****************************************************************
      // Compare outputs; channel 0 pin carries the linked pair
      // ****************************************************************
      if (chanLevel[0] || (linked && gChan[0].els && gChan[1].match))
        chan0PinOut <= chanSc[0][`TCC_CH_ELS_HI] ? (chanSc[0][`TCC_CH_ELS_LO] ?
                       !chan0PinOut : 1'b0) : 1'b1;
      else if (wrap && chanSc[0][`TCC_CH_TOV] && (chanSc[0][`TCC_CH_MODE] || linked))
        chan0PinOut <= !chan0PinOut;
      if (chanLevel[1])
        chan1PinOut <= chanSc[1][`TCC_CH_ELS_HI] ? (chanSc[1][`TCC_CH_ELS_LO] ?
                       !chan1PinOut : 1'b0) : 1'b1;
      else if (wrap && chanSc[1][`TCC_CH_TOV] && chanSc[1][`TCC_CH_MODE] && !linked)
        chan1PinOut <= !chan1PinOut;

      // ****************************************************************
      // Software writes
      // ****************************************************************
      if (doWrite && wLane) begin
        case (wIdx)
          `TCC_IDX_STATUS: begin
            status[6:5] <= wByte[6:5];
            status[2:0] <= wByte[2:0];
            if (!wByte[`TCC_ST_OVF] && ovfArm)
              status[`TCC_ST_OVF] <= 1'b0;
            if (wByte[`TCC_ST_CLR]) begin
              counter  <= {CNT_W{1'b0}};
              prescale <= 6'h0;
            end
          end
          `TCC_IDX_MOD_HI: modulo[15:8] <= wByte;
          `TCC_IDX_MOD_LO: modulo[7:0]  <= wByte;
          `TCC_IDX_CH0_SC: begin
            chanSc[0][6:0] <= wByte[6:0];
            if (!wByte[`TCC_CH_FLAG] && chanArm[0])
              chanSc[0][`TCC_CH_FLAG] <= 1'b0;
          end
          `TCC_IDX_CH1_SC: begin
            chanSc[1][6:0] <= {wByte[6], 1'b0, wByte[4:0]};
            if (!wByte[`TCC_CH_FLAG] && chanArm[1])
              chanSc[1][`TCC_CH_FLAG] <= 1'b0;
          end
          `TCC_IDX_CH0_HI: chanVal[0][15:8] <= wByte;
          `TCC_IDX_CH0_LO: chanVal[0][7:0]  <= wByte;
          `TCC_IDX_CH1_HI: chanVal[1][15:8] <= wByte;
          `TCC_IDX_CH1_LO: chanVal[1][7:0]  <= wByte;
          default: ;
        endcase
        if (wIdx == `TCC_IDX_STATUS)
          ovfArm <= 1'b0;
        if (wIdx == `TCC_IDX_CH0_SC)
          chanArm[0] <= 1'b0;
        if (wIdx == `TCC_IDX_CH1_SC)
          chanArm[1] <= 1'b0;
      end

      // ****************************************************************
      // Reading a set flag arms its clear
      // ****************************************************************
      // A blind write of 0 then cannot lose an event it never saw
      if (doRead && rIdx == `TCC_IDX_STATUS && status[`TCC_ST_OVF])
        ovfArm <= 1'b1;
      if (doRead && rIdx == `TCC_IDX_CH0_SC && chanSc[0][`TCC_CH_FLAG])
        chanArm[0] <= 1'b1;
      if (doRead && rIdx == `TCC_IDX_CH1_SC && chanSc[1][`TCC_CH_FLAG])
        chanArm[1] <= 1'b1;

      // ****************************************************************
      // Hardware sets placed last so a set beats a same-cycle clear
      // ****************************************************************
      if (wrap)
        status[`TCC_ST_OVF] <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
        if (chanEvent[i])
          chanSc[i][`TCC_CH_FLAG] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupts and pin enables
  // ****************************************************************
  assign overflowIrq = status[`TCC_ST_OVF] & status[`TCC_ST_OVIE];
  assign chan0Irq    = chanSc[0][`TCC_CH_FLAG] & chanSc[0][`TCC_CH_IE];
  // Linked channel 1 raises no request of its own
  assign chan1Irq    = chanSc[1][`TCC_CH_FLAG] & chanSc[1][`TCC_CH_IE] & !linked;
  assign chan0PinOe  = chanSc[0][`TCC_CH_MODE] | linked;
  assign chan1PinOe  = chanSc[1][`TCC_CH_MODE] & !linked;

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped offsets answer with a slave error
  reg [7:0] rByte;
  reg       rHit;
  always @* begin
    rHit  = 1'b1;
    rByte = 8'h0;
    case (rIdx)
      `TCC_IDX_STATUS: rByte = {status[7:5], 2'b00, status[2:0]};
      `TCC_IDX_CNT_HI: rByte = counter[15:8];
      `TCC_IDX_CNT_LO: rByte = counter[7:0];
      `TCC_IDX_MOD_HI: rByte = modulo[15:8];
      `TCC_IDX_MOD_LO: rByte = modulo[7:0];
      `TCC_IDX_CH0_SC: rByte = chanSc[0];
      `TCC_IDX_CH0_HI: rByte = chanVal[0][15:8];
      `TCC_IDX_CH0_LO: rByte = chanVal[0][7:0];
      `TCC_IDX_CH1_SC: rByte = chanSc[1] & 8'hdf;
      `TCC_IDX_CH1_HI: rByte = chanVal[1][15:8];
      `TCC_IDX_CH1_LO: rByte = chanVal[1][7:0];
      default:         rHit  = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h0;
    end else begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, rByte};
        s_axi_rresp  <= rHit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== bench/tcc_timer_props.sv ====
module tcc_timer_props (
  // Clock and reset
  input logic        core_clk,
  input logic        rstn,
  // Bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // Interrupt requests
  input logic        overflowIrq,
  input logic        chan0Irq,
  input logic        chan1Irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [2:0] wrAge;
  // Age of last data beat: a flag may only drop shortly after a write
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) wrAge <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wrAge <= 3'h0;
    else if (wrAge != 3'h7) wrAge <= wrAge + 3'h1;
  end
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_write_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unused read bits set");
  a_irq_reset: assert property ($rose(rstn) |-> !(overflowIrq || chan0Irq || chan1Irq))
    else $error("request active after reset");
  a_flag_clear: assert property ($fell(chan0Irq) |-> wrAge < 3'h5)
    else $error("channel request dropped without write");
  a_ovf_clear: assert property ($fell(overflowIrq) |-> wrAge < 3'h5)
    else $error("overflow request dropped without write");
endmodule

bind tcc_timer tcc_timer_props u_props (.core_clk, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .overflowIrq, .chan0Irq,
  .chan1Irq);

// ==== bench/tcc_pin_model.sv ====
module tcc_pin_model (
  // Clock
  input  wire logic core_clk,
  // Design side of the channel pins
  input  wire logic chan0PinOut,
  input  wire logic chan0PinOe,
  input  wire logic chan1PinOut,
  input  wire logic chan1PinOe,
  // Levels at the pins
  output logic      extTimerClockPin,
  output wire logic chan0PinIn,
  output wire logic chan1PinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv0 = 1'b0;
  logic drv1 = 1'b0;
  // Design owns the wire while enabled; no pull, so the model drives otherwise
  assign chan0PinIn = chan0PinOe ? chan0PinOut : drv0;
  assign chan1PinIn = chan1PinOe ? chan1PinOut : drv1;
  initial extTimerClockPin = 1'b0;
  // Two core cycles high a pulse so the synchroniser sees it; still between bursts
  task ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      extTimerClockPin <= 1'b1;
      repeat (2) @(posedge core_clk);
      extTimerClockPin <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  task setPin(input int ch, input logic v);
    @(posedge core_clk);
    if (ch == 0) drv0 <= v;
    else drv1 <= v;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// ==== bench/test_tcc_timer.sv ====
`include "tcc_defines.vh"
module test_tcc_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  r;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         extTimerClockPin, chan0PinIn, chan1PinIn, chan0PinOut, chan0PinOe;
  wire         chan1PinOut, chan1PinOe, overflowIrq, chan0Irq, chan1Irq;
  int          miscompares, n_compared, c;
  logic [1:0]  els [4] = '{2'h1, 2'h3, 2'h1, 2'h2};
  logic        pinExp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tcc_timer dut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .extTimerClockPin, .chan0PinIn, .chan1PinIn, .chan0PinOut, .chan0PinOe,
    .chan1PinOut, .chan1PinOe, .overflowIrq, .chan0Irq, .chan1Irq);
  tcc_pin_model pins (.core_clk, .chan0PinOut, .chan0PinOe, .chan1PinOut, .chan1PinOe,
    .extTimerClockPin, .chan0PinIn, .chan1PinIn);

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // ********
  // Tasks
  // ********
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Requests held until their own handshake edge; answer taken at that edge
  task wr(input logic [7:0] idx, input logic [7:0] v);
    logic a, w, b;
    int t;
    @(posedge core_clk);
    s_axi_awaddr <= {idx[5:0], 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(negedge core_clk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge core_clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      t++;
    end while (!b && t < 50);
    chk(b, 1'b1);
  endtask
  task rd(input logic [7:0] idx);
    logic a, v;
    int t;
    @(posedge core_clk);
    s_axi_araddr <= {idx[5:0], 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(negedge core_clk);
      a = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (a) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
      t++;
    end while (!v && t < 50);
    chk(v, 1'b1);
  endtask
  task rdc(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(d, exp);
  endtask
  task stop_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rdc(`TCC_IDX_STATUS, 32'h20);
    rdc(`TCC_IDX_CNT_LO, 32'h0);
    rdc(`TCC_IDX_MOD_HI, 32'hff);
    rdc(`TCC_IDX_CH1_SC, 32'h0);
    wr(`TCC_IDX_CNT_HI, 8'h5a);
    rdc(`TCC_IDX_CNT_HI, 32'h0);
    rd(8'h30);
    chk(r, 2'h2);
    for (int p = 0; p < 8; p++) begin
      wr(`TCC_IDX_STATUS, 8'h20 + p[7:0]);
      rdc(`TCC_IDX_STATUS, 32'h20 + p);
    end
    wr(`TCC_IDX_MOD_HI, 8'h00);
    wr(`TCC_IDX_MOD_LO, 8'h09);
    rdc(`TCC_IDX_MOD_LO, 32'h9);
    wr(`TCC_IDX_STATUS, 8'h40);
    repeat (3) begin
      rd(`TCC_IDX_CNT_LO);
      chk(d <= 32'h9, 1'b1);
    end
    wr(`TCC_IDX_STATUS, 8'h60);
    rdc(`TCC_IDX_STATUS, 32'he0);
    chk(overflowIrq, 1'b1);
    wr(`TCC_IDX_STATUS, 8'h60);
    rdc(`TCC_IDX_STATUS, 32'h60);
    chk(overflowIrq, 1'b0);
    wr(`TCC_IDX_MOD_LO, 8'hff);
    wr(`TCC_IDX_STATUS, 8'h17);
    pins.ticks(5);
    rdc(`TCC_IDX_CNT_LO, 32'h5);
    rdc(`TCC_IDX_CNT_LO, 32'h5);
    wr(`TCC_IDX_CH0_SC, 8'h44);
    pins.setPin(0, 1'b1);
    rdc(`TCC_IDX_CH0_LO, 32'h5);
    chk(chan0Irq, 1'b1);
    wr(`TCC_IDX_CH1_LO, 8'h55);
    wr(`TCC_IDX_CH1_SC, 8'h68);
    pins.setPin(1, 1'b1);
    rdc(`TCC_IDX_CH1_LO, 32'h55);
    pins.ticks(1);
    pins.setPin(1, 1'b0);
    rdc(`TCC_IDX_CH1_LO, 32'h6);
    chk(chan1Irq, 1'b1);
    rdc(`TCC_IDX_CH1_SC, 32'hc8);
    wr(`TCC_IDX_CH1_SC, 8'h48);
    chk(chan1Irq, 1'b0);
    c = 6;
    wr(`TCC_IDX_CH0_HI, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(`TCC_IDX_CH0_SC);
      wr(`TCC_IDX_CH0_SC, {4'h5, els[i], 2'h0});
      c += 2;
      wr(`TCC_IDX_CH0_LO, c[7:0]);
      pins.ticks(2);
      repeat (4) @(posedge core_clk);
      chk(chan0PinOut, pinExp[i]);
      chk(chan0Irq, 1'b1);
      chk(chan0PinOe, 1'b1);
    end
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
endmodule
